/* File: core/cwf_ctrl.v */
// cwf_ctrl.v: two independent can transceiver channel controllers:
// wake pattern detection, tx dominant time-out, undervoltage and
// overtemperature handling. bus, supply and temperature inputs come
// in as digital flags synchronous to clk.
// counters assume the map's figures fit their widths.
//
// How it works
// - each channel owns its wake detector
// - wake needs dominant, recessive, dominant phases
// - short interposed bits are ignored
// - pattern must finish in wake window
// - rx held high until wake event
// - after wake, rx mirrors filtered bus
// - phases under filter time are not seen
// - normal mode, timeout, standby undervoltage reset detector
// - tx low edge starts dominant timer
// - tx low too long disables transmitter
// - tx high clears dominant timer
// - each channel has its own timer
// - undriven tx and mode inputs read high
// - standby undervoltage forces low-power, ignores select
// - after undervoltage, tx ignored until seen high
// - switch-off undervoltage floats bus pins
// - overtemperature disables bus drivers
// - drivers return once tx goes high
// - per-channel supply and thermal supervision
// - select low normal, high low-power
// - wake phase thresholds within 0.5..3 us
// - wake window within 0.8..6.5 ms
// - tx dominant timeout within 0.8..6.5 ms
`timescale 1ns/100ps
`include "cwf_map.vh"

module cwf_chan #(
  parameter integer WAKE_TO_CYC = `CWF_WAKE_TO_CYC,
  parameter integer TXDOM_TO_CYC = `CWF_TXDOM_TO_CYC
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // host side; pads pulled high, so floating reads 1
  input wire tx_data_in,
  input wire lowpower_select,
  output reg rx_data_out,
  // bus side: 1 = recessive
  input wire bus_rec_lp,
  input wire bus_rec_norm,
  output wire drv_dominant,
  output wire bus_float,
  // supervision flags
  input wire uv_standby,
  input wire uv_switchoff,
  input wire over_temp,
  // status
  output wire normal_mode,
  output wire wake_flag
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_DOM1 = 2'h1;
  localparam [1:0] ST_REC = 2'h2;
  localparam [1:0] ST_DOM2 = 2'h3;
  // figures worked out as integers, then cut to the counter widths;
  // every count in the map fits, so the cut loses nothing
  localparam integer DOM_CYC_I = `CWF_WAKE_DOM_CYC;
  localparam integer REC_CYC_I = `CWF_WAKE_REC_CYC;
  localparam integer FLT_CYC_I = `CWF_FILTER_CYC;
  localparam [7:0] DOM_CYC = DOM_CYC_I[7:0];
  localparam [7:0] REC_CYC = REC_CYC_I[7:0];
  localparam [7:0] FLT_CYC = FLT_CYC_I[7:0];
  localparam [16:0] WIN_LIM = WAKE_TO_CYC[16:0];
  localparam [16:0] TXTO_LIM = TXDOM_TO_CYC[16:0];
  // run counter stops here instead of wrapping back to a short run
  localparam [7:0] PH_MAX = 8'hff;

  reg [1:0] st_q;
  reg [7:0] flt_cnt_q;
  reg flt_bus_q;
  reg [7:0] ph_cnt_q;
  reg [16:0] win_cnt_q;
  reg woke_q;
  reg [16:0] txto_cnt_q;
  reg txto_q;
  reg tx_prev_q;
  reg uv_lock_q;
  reg ot_lock_q;
  wire lp_mode;
  wire tx_eff;
  wire mode_forced;
  wire drv_block;
  wire det_abort;
  wire win_expired;

  // undervoltage overrides select; select high is low-power
  assign mode_forced = uv_standby | uv_switchoff;
  assign lp_mode = mode_forced | lowpower_select;
  assign normal_mode = ~lp_mode;
  assign wake_flag = woke_q;
  assign tx_eff = tx_data_in | uv_lock_q;
  // any fail-safe holds the driver off, whatever tx asks for
  assign drv_block = txto_q | ot_lock_q | over_temp;
  // idle inputs read high, so a floating host never drives dominant
  assign drv_dominant = normal_mode & ~tx_eff & ~drv_block;
  assign bus_float = uv_switchoff;
  // leaving low-power or a standby undervoltage drops a pattern in progress
  assign det_abort = !lp_mode || uv_standby;
  // window counts only while a pattern is under way
  assign win_expired = (st_q != ST_IDLE) && (win_cnt_q >= WIN_LIM - 17'h1);

  // low-power receiver filter: accept new level after stable time
  // any bounce restarts the count: a hold-off, not a vote
  always @(posedge clk) begin
    if (srst) begin
      flt_cnt_q <= 8'h00;
      flt_bus_q <= 1'b1;
    end else if (bus_rec_lp == flt_bus_q) begin
      flt_cnt_q <= 8'h00;
    end else if (flt_cnt_q >= FLT_CYC - 8'h01) begin
      flt_bus_q <= bus_rec_lp;
      flt_cnt_q <= 8'h00;
    end else begin
      flt_cnt_q <= flt_cnt_q + 8'h01;
    end
  end

  // wake detector; phase counter measures the run of the filtered level st_q hunts for
  // the steps of the pattern live in st_q; the window only runs
  // once the first dominant phase has been accepted
  always @(posedge clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      ph_cnt_q <= 8'h00;
      win_cnt_q <= 17'h00000;
      woke_q <= 1'b0;
    end else if (det_abort) begin
      st_q <= ST_IDLE;
      ph_cnt_q <= 8'h00;
      win_cnt_q <= 17'h00000;
      // a supply dip keeps a wake already seen, normal mode clears it
      woke_q <= uv_standby ? woke_q : 1'b0;
    end else if (win_expired) begin
      st_q <= ST_IDLE;
      ph_cnt_q <= 8'h00;
      win_cnt_q <= 17'h00000;
    end else begin
      if (st_q != ST_IDLE)
        win_cnt_q <= win_cnt_q + 17'h1;
      // count run length; short interposed runs never reach a limit
      if (flt_bus_q != tx_prev_dummy(st_q))
        ph_cnt_q <= 8'h00;
      else if (ph_cnt_q != PH_MAX)
        ph_cnt_q <= ph_cnt_q + 8'h01;
      case (st_q)
        ST_IDLE: begin
          if (phase_done(!flt_bus_q, ph_cnt_q, DOM_CYC)) begin
            st_q <= ST_DOM1;
            win_cnt_q <= 17'h00000;
            ph_cnt_q <= 8'h00;
          end
        end
        ST_DOM1: begin
          if (phase_done(flt_bus_q, ph_cnt_q, REC_CYC)) begin
            st_q <= ST_REC;
            ph_cnt_q <= 8'h00;
          end
        end
        ST_REC: begin
          if (phase_done(!flt_bus_q, ph_cnt_q, DOM_CYC)) begin
            st_q <= ST_IDLE;
            woke_q <= 1'b1;
            ph_cnt_q <= 8'h00;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // level the current state is hunting for: 0 dominant, 1 recessive
  function tx_prev_dummy;
    input [1:0] s;
    begin
      tx_prev_dummy = (s == ST_DOM1) ? 1'b1 : 1'b0;
    end
  endfunction

  // a phase counts once the filtered level has stood long enough;
  // the two-cycle allowance covers the run counter's own lag
  function phase_done;
    input lvl_ok;
    input [7:0] cnt;
    input [7:0] lim;
    begin
      phase_done = lvl_ok && (cnt >= lim - 8'h02);
    end
  endfunction

  // tx dominant time-out timer, own per channel
  // runs in low-power too; harmless, the driver is off there anyway
  // the flag stays set until tx returns high, so no retry storm
  always @(posedge clk) begin
    if (srst) begin
      tx_prev_q <= 1'b1;
      txto_cnt_q <= 17'h00000;
      txto_q <= 1'b0;
    end else begin
      tx_prev_q <= tx_eff;
      if (tx_eff) begin
        txto_cnt_q <= 17'h00000;
        txto_q <= 1'b0;
      end else if (tx_prev_q) begin
        txto_cnt_q <= 17'h00001;
      end else if (txto_cnt_q >= TXTO_LIM) begin
        txto_q <= 1'b1;
      end else begin
        txto_cnt_q <= txto_cnt_q + 17'h1;
      end
    end
  end

  // recovery locks: tx must be seen high before driving again
  // a new fault in the clearing cycle wins, keeping the lock set
  always @(posedge clk) begin
    if (srst) begin
      uv_lock_q <= 1'b0;
      ot_lock_q <= 1'b0;
    end else begin
      if (mode_forced)
        uv_lock_q <= 1'b1;
      else if (tx_data_in)
        uv_lock_q <= 1'b0;
      if (over_temp)
        ot_lock_q <= 1'b1;
      else if (tx_data_in)
        ot_lock_q <= 1'b0;
    end
  end

  // rx: normal receiver, or filtered bus once woken, else high
  // registered so the host never sees a decode glitch
  always @(posedge clk) begin
    if (srst)
      rx_data_out <= 1'b1;
    else if (normal_mode)
      rx_data_out <= bus_rec_norm;
    else if (woke_q)
      rx_data_out <= flt_bus_q;
    else
      rx_data_out <= 1'b1;
  end
endmodule

module cwf_ctrl #(
  // time-outs are parameters so a bench can shorten them
  parameter integer WAKE_TO_CYC = `CWF_WAKE_TO_CYC,
  parameter integer TXDOM_TO_CYC = `CWF_TXDOM_TO_CYC
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // host side, bit n is channel n
  input wire [1:0] tx_data_in,
  input wire [1:0] lowpower_select,
  output wire [1:0] rx_data_out,
  // bus side
  input wire [1:0] bus_rec_lp,
  input wire [1:0] bus_rec_norm,
  output wire [1:0] drv_dominant,
  output wire [1:0] bus_float,
  // supervision, one per channel
  input wire [1:0] uv_standby,
  input wire [1:0] uv_switchoff,
  input wire [1:0] over_temp,
  // status
  output wire [1:0] normal_mode,
  output wire [1:0] wake_flag
);
  // two fully separate channels
  // nothing is shared between them but clock and reset
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_ch
      cwf_chan #(
        .WAKE_TO_CYC(WAKE_TO_CYC),
        .TXDOM_TO_CYC(TXDOM_TO_CYC)
      ) u_ch (
        .clk(clk),
        .srst(srst),
        .tx_data_in(tx_data_in[i]),
        .lowpower_select(lowpower_select[i]),
        .rx_data_out(rx_data_out[i]),
        .bus_rec_lp(bus_rec_lp[i]),
        .bus_rec_norm(bus_rec_norm[i]),
        .drv_dominant(drv_dominant[i]),
        .bus_float(bus_float[i]),
        .uv_standby(uv_standby[i]),
        .uv_switchoff(uv_switchoff[i]),
        .over_temp(over_temp[i]),
        .normal_mode(normal_mode[i]),
        .wake_flag(wake_flag[i])
      );
    end
  endgenerate
endmodule

/* File: core/cwf_map.vh */
// cwf_map.vh: timing figures and derived cycle counts for the
// per-channel wake, time-out and protection logic.
// assumes a 20 mhz system clock; included by the channel controller.
`ifndef CWF_MAP_VH
`define CWF_MAP_VH

`define CWF_CLK_HZ 20000000
// wake phase thresholds, nanoseconds (range 500..3000)
`define CWF_WAKE_DOM_NS 2000
`define CWF_WAKE_REC_NS 2000
// low-power receiver glitch filter, nanoseconds (range 500..3000)
`define CWF_FILTER_NS 1000
// wake pattern window and tx dominant time-out, microseconds
`define CWF_WAKE_TO_US 3000
`define CWF_TXDOM_TO_US 3000

// least times round up, longest times round down
`define CWF_WAKE_DOM_CYC ((`CWF_WAKE_DOM_NS * 20 + 999) / 1000)
`define CWF_WAKE_REC_CYC ((`CWF_WAKE_REC_NS * 20 + 999) / 1000)
`define CWF_FILTER_CYC ((`CWF_FILTER_NS * 20 + 999) / 1000)
`define CWF_WAKE_TO_CYC (`CWF_WAKE_TO_US * 20)
`define CWF_TXDOM_TO_CYC (`CWF_TXDOM_TO_US * 20)

// counter widths
`define CWF_SHORT_W 8
`define CWF_LONG_W 17

`endif

/* File: sim/cwf_bus.sv */
// cwf_bus.sv: two-channel bus wire seen by both receivers.
// assumes 1 = recessive; node_dom stands for the other nodes.
`timescale 1ns/100ps
module cwf_bus (
  // drivers
  input wire [1:0] drv_dominant,
  input wire [1:0] node_dom,
  // receivers
  output wire [1:0] bus_rec_lp,
  output wire [1:0] bus_rec_norm
);
  // bias resistors hold recessive unless some node drives
  assign bus_rec_norm = ~(drv_dominant | node_dom);
  assign bus_rec_lp = bus_rec_norm;
endmodule

/* File: sim/cwf_ctrl_chk.sv */
// cwf_ctrl_chk.sv: port checks on channel 0 of the controller.
// assumes binding onto cwf_ctrl; channel 1 is the same logic.
`timescale 1ns/100ps
module cwf_chk #(
  parameter integer WAKE_TO_CYC = 32'h00000190,
  parameter integer TXDOM_TO_CYC = 32'h000000c8
) (
  // clock, reset, host side
  input wire clk,
  input wire srst,
  input wire [1:0] tx_data_in,
  input wire [1:0] lowpower_select,
  input wire [1:0] rx_data_out,
  // bus, supervision, status
  input wire [1:0] bus_rec_lp,
  input wire [1:0] bus_rec_norm,
  input wire [1:0] drv_dominant,
  input wire [1:0] bus_float,
  input wire [1:0] uv_standby,
  input wire [1:0] uv_switchoff,
  input wire [1:0] over_temp,
  input wire [1:0] normal_mode,
  input wire [1:0] wake_flag
);
  reg [16:0] low_q;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // normal-mode tx low run; short runs only, so no wrap
  always @(posedge clk) begin
    if (srst || tx_data_in[0] || !normal_mode[0])
      low_q <= 17'h0;
    else
      low_q <= low_q + 17'h1;
  end
  sequence s_fall; tx_data_in[0] && normal_mode[0] && !over_temp[0]
    ##1 !tx_data_in[0] && normal_mode[0] && !over_temp[0]; endsequence
  sequence s_ot_off;
    over_temp[0] ##1 !over_temp[0] && !tx_data_in[0]; endsequence
  property p_start; s_fall |-> drv_dominant[0]; endproperty
  a_start: assert property (p_start) else $error("no dominant");
  property p_ot_rec; s_ot_off |-> !drv_dominant[0]; endproperty
  a_ot_rec: assert property (p_ot_rec) else $error("early drive");
  property p_to; low_q > TXDOM_TO_CYC + 17'h2 |-> !drv_dominant[0];
  endproperty
  a_to: assert property (p_to) else $error("no timeout");
  property p_ot; over_temp[0] |-> !drv_dominant[0]; endproperty
  a_ot: assert property (p_ot) else $error("hot drive");
  property p_uv; uv_standby[0] |-> !normal_mode[0]; endproperty
  a_uv: assert property (p_uv) else $error("uv normal");
  property p_float; bus_float[0] == uv_switchoff[0]; endproperty
  a_float: assert property (p_float) else $error("float");
  property p_clr; normal_mode[0] [*2] |-> !wake_flag[0]; endproperty
  a_clr: assert property (p_clr) else $error("wake kept");
  property p_hold; (!normal_mode[0] && !wake_flag[0]) [*2]
    ##1 !wake_flag[0] |-> $past(rx_data_out[0]); endproperty
  a_hold: assert property (p_hold) else $error("rx low");
endmodule
bind cwf_ctrl cwf_chk #(.WAKE_TO_CYC(WAKE_TO_CYC),
  .TXDOM_TO_CYC(TXDOM_TO_CYC)) chk_u (.clk(clk), .srst(srst),
  .tx_data_in(tx_data_in), .lowpower_select(lowpower_select),
  .rx_data_out(rx_data_out), .bus_rec_lp(bus_rec_lp),
  .bus_rec_norm(bus_rec_norm), .drv_dominant(drv_dominant),
  .bus_float(bus_float), .uv_standby(uv_standby),
  .uv_switchoff(uv_switchoff), .over_temp(over_temp),
  .normal_mode(normal_mode), .wake_flag(wake_flag));

/* File: sim/test_can_wake_failsafe_ctrl.sv */
// test_can_wake_failsafe_ctrl.sv: self-checking bench for cwf_ctrl.
// assumes cwf_bus as the wire; time-outs shortened to keep runs short.
`timescale 1ns/100ps
module test_can_wake_failsafe_ctrl;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg [1:0] tx = 2'b11, sel = 2'b11, nd = 2'b00, pb;
  reg [1:0] uvs = 2'b00, uvo = 2'b00, ot = 2'b00;
  wire [1:0] rx, lp, nr, drv, fl, nm, wk;
  integer failures = 0, n_tests = 0, seed = 32'h7d75, i;
  always #25 clk = ~clk;
  cwf_ctrl #(.WAKE_TO_CYC(17'h00190), .TXDOM_TO_CYC(17'h000c8)) dut_u (
    .clk(clk), .srst(srst), .tx_data_in(tx), .lowpower_select(sel),
    .rx_data_out(rx), .bus_rec_lp(lp), .bus_rec_norm(nr),
    .drv_dominant(drv), .bus_float(fl), .uv_standby(uvs),
    .uv_switchoff(uvo), .over_temp(ot), .normal_mode(nm), .wake_flag(wk));
  cwf_bus bus_u (.drv_dominant(drv), .node_dom(nd), .bus_rec_lp(lp),
    .bus_rec_norm(nr));
  // driver state expected in clean normal mode
  function [1:0] f_drv(input [1:0] t, input [1:0] s);
    f_drv = ~t & ~s;
  endfunction
  task chk(input [1:0] seen, input [1:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("MISMATCH %0t seen %b want %b", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // another node holds the channel 0 bus level
  task ph(input lvl, input integer n);
    begin
      nd[0] = lvl;
      cyc(n);
    end
  endtask
  // one recessive cycle, then both tx low again
  task rel;
    begin
      tx = 2'b11;
      cyc(1);
      tx = 2'b00;
      cyc(1);
    end
  endtask
  task print_verdict;
    begin
      if (failures == 0 && n_tests > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // hang guard, far past the roughly 1670 cycles needed
  initial begin
    cyc(20000);
    failures = failures + 1;
    print_verdict;
  end
  initial begin
    cyc(5);
    srst = 1'b0;
    ph(1, 70);
    ph(0, 420);
    ph(1, 70);
    ph(0, 450);
    chk(wk, 2'b00);
    ph(1, 70);
    chk(rx, 2'b11);
    ph(0, 70);
    // dominant run longer than the filter, shorter than a wake phase
    ph(1, 30);
    ph(0, 30);
    chk(wk, 2'b00);
    ph(1, 70);
    chk(wk, 2'b01);
    ph(0, 30);
    ph(1, 30);
    chk(rx, 2'b10);
    ph(0, 30);
    ph(1, 5);
    ph(0, 3);
    chk(rx, 2'b11);
    sel = 2'b00;
    cyc(2);
    chk(wk, 2'b00);
    pb = nr;
    // random tx on both channels in normal mode
    for (i = 0; i < 60; i = i + 1) begin
      chk(rx, pb);
      tx = $random(seed);
      #1;
      chk(drv, f_drv(tx, sel));
      pb = nr;
      cyc(1);
    end
    tx = 2'b00;
    cyc(150);
    chk(drv, 2'b11);
    tx = 2'b10;
    cyc(60);
    chk(drv, 2'b00);
    rel;
    chk(drv, 2'b11);
    ot = 2'b01;
    cyc(1);
    chk(drv, 2'b10);
    ot = 2'b00;
    cyc(1);
    chk(drv, 2'b10);
    rel;
    chk(drv, 2'b11);
    uvs = 2'b01;
    cyc(1);
    chk(nm, 2'b10);
    uvs = 2'b00;
    cyc(1);
    chk(drv, 2'b10);
    rel;
    chk(drv, 2'b11);
    uvo = 2'b01;
    cyc(1);
    chk(fl, 2'b01);
    print_verdict;
  end
endmodule
